// >>> shared/icc_defs.vh
// Constants for the input conditioning command interpreter
`ifndef ICC_DEFS_VH
`define ICC_DEFS_VH

// APB register byte offsets
`define ICC_ADDR_W        8
`define ICC_OFS_CTRL      8'h00
`define ICC_OFS_STATUS    8'h04
`define ICC_OFS_SETTINGS  8'h08
`define ICC_OFS_LEVEL_A   8'h0c
`define ICC_OFS_LEVEL_B   8'h10

// Control register fields
`define ICC_CTRL_REMOTE   0
`define ICC_CTRL_CHECK    1
`define ICC_CTRL_RESET    2'h0

// Channel setting word: {atten[1:0], slope_neg, coupling_ac}
`define ICC_SET_W         4
`define ICC_SET_AC        0
`define ICC_SET_SLOPE     1
`define ICC_SET_ATT_LO    2
`define ICC_SET_ATT_HI    3
`define ICC_ATT_X1        2'h0
`define ICC_ATT_X10       2'h1
`define ICC_ATT_X100      2'h2

// Start-up and check-mode values
`define ICC_SET_DEFAULT   4'h0
`define ICC_SEP_DEFAULT   1'b0
`define ICC_INV_DEFAULT   1'b0
`define ICC_SET_CHECK     4'h0
`define ICC_LEVEL_DEFAULT 13'h0000

// Level word: {negative, volts, hundreds of mV, tens of mV}
`define ICC_LEVEL_W       13
`define ICC_LEVEL_DIGITS  2'h3

// Command characters
`define ICC_CH_A          8'h41
`define ICC_CH_B          8'h42
`define ICC_CH_INIT       8'h50
`define ICC_CH_PLUS       8'h2b
`define ICC_CH_MINUS      8'h2d
`define ICC_CH_STAR       8'h2a
`define ICC_CH_ZERO       8'h30
`define ICC_CH_NINE       8'h39

`endif

// >>> logic/icc_level_shift.v
// Trigger-level shift register for one channel
`timescale 1ns/1ps
`default_nettype none
`include "icc_defs.vh"

module icc_level_shift #(
  parameter [`ICC_LEVEL_W-1:0] LEVEL_DEFAULT = `ICC_LEVEL_DEFAULT
) (
  // Clock and reset
  input  wire                    i_mclk,
  input  wire                    i_reset_n,
  // Loading
  input  wire                    i_clear,
  input  wire                    i_load_sign,
  input  wire                    i_negative,
  input  wire                    i_load_digit,
  input  wire [3:0]              i_digit,
  // Result
  output wire [`ICC_LEVEL_W-1:0] o_level,
  output wire [1:0]              o_count
);

  reg [`ICC_LEVEL_W-1:0] level_reg;
  reg [1:0]              count_reg;

  // Sign restarts the entry; digits shift in at the low end, volts end on top
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_reg <= LEVEL_DEFAULT;
      count_reg <= 2'h0;
    end else if (i_clear) begin
      level_reg <= LEVEL_DEFAULT;
      count_reg <= 2'h0;
    end else if (i_load_sign) begin
      level_reg <= {i_negative, 12'h000};
      count_reg <= 2'h0;
    end else if (i_load_digit && (count_reg != `ICC_LEVEL_DIGITS)) begin
      // A fourth digit is dropped so a long entry cannot shift volts out
      level_reg <= {level_reg[12], level_reg[7:0], i_digit};
      count_reg <= count_reg + 2'h1;
    end
  end

  assign o_level = level_reg;
  assign o_count = count_reg;

endmodule
`default_nettype wire

// >>> logic/icc_interpreter.v
// Input conditioning command interpreter with APB control and status
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "icc_defs.vh"

module icc_interpreter #(
  parameter [`ICC_SET_W-1:0]   SET_DEFAULT   = `ICC_SET_DEFAULT,
  parameter                    SEP_DEFAULT   = `ICC_SEP_DEFAULT,
  parameter                    INV_DEFAULT   = `ICC_INV_DEFAULT,
  parameter [`ICC_SET_W-1:0]   SET_CHECK     = `ICC_SET_CHECK,
  parameter [`ICC_LEVEL_W-1:0] LEVEL_DEFAULT = `ICC_LEVEL_DEFAULT
) (
  // Clock and reset
  input  wire                    i_mclk,
  input  wire                    i_reset_n,
  // APB slave
  input  wire                    i_psel,
  input  wire                    i_penable,
  input  wire                    i_pwrite,
  input  wire [`ICC_ADDR_W-1:0]  i_paddr,
  input  wire [31:0]             i_pwdata,
  output reg  [31:0]             o_prdata,
  output reg                     o_pready,
  output reg                     o_pslverr,
  // Remote command path, asynchronous pins
  input  wire [3:0]              i_command_data_lines,
  input  wire                    i_cmd_strobe,
  input  wire                    i_dev_clear,
  // Front panel switches, asynchronous pins
  input  wire [`ICC_SET_W-1:0]   i_fp_a_sw,
  input  wire [`ICC_SET_W-1:0]   i_fp_b_sw,
  input  wire                    i_fp_separate_common,
  input  wire                    i_fp_invert,
  // Channel A relay controls
  output reg                     o_a_coupling_select,
  output reg                     o_a_slope_neg,
  output reg                     o_a_atten_x100,
  output reg                     o_a_atten_x10,
  output reg                     o_a_atten_x1,
  // Channel B relay controls
  output reg                     o_b_coupling_select,
  output reg                     o_b_slope_neg,
  output reg                     o_b_atten_x100,
  output reg                     o_b_atten_x10,
  output reg                     o_b_atten_x1,
  // Shared relay controls and converter words
  output reg                     o_separate_common_select,
  output reg                     o_invert,
  output reg                     o_level_src_dac,
  output reg  [`ICC_LEVEL_W-1:0] o_a_level,
  output reg  [`ICC_LEVEL_W-1:0] o_b_level
);

  // Two-stage synchronisers for every pin input
  localparam SYNC_W = 4 + 2 + 2 * `ICC_SET_W + 2;
  wire [SYNC_W-1:0] pins_async;
  reg  [SYNC_W-1:0] sync1_reg;
  reg  [SYNC_W-1:0] sync2_reg;

  assign pins_async = {i_command_data_lines, i_cmd_strobe, i_dev_clear,
                       i_fp_a_sw, i_fp_b_sw, i_fp_separate_common, i_fp_invert};

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= {SYNC_W{1'b0}};
      sync2_reg <= {SYNC_W{1'b0}};
    end else begin
      sync1_reg <= pins_async;
      sync2_reg <= sync1_reg;
    end
  end

  wire [3:0]            nib_s   = sync2_reg[SYNC_W-1:SYNC_W-4];
  wire                  stb_s   = sync2_reg[SYNC_W-5];
  wire                  dclr_s  = sync2_reg[SYNC_W-6];
  wire [`ICC_SET_W-1:0] fpa_s   = sync2_reg[2*`ICC_SET_W+1:`ICC_SET_W+2];
  wire [`ICC_SET_W-1:0] fpb_s   = sync2_reg[`ICC_SET_W+1:2];
  wire                  fpsep_s = sync2_reg[1];
  wire                  fpinv_s = sync2_reg[0];

  // Edge detectors on synchronised strobe and clear
  reg stb_d_reg;
  reg dclr_d_reg;
  wire stb_rise  = stb_s & ~stb_d_reg;
  wire dclr_rise = dclr_s & ~dclr_d_reg;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stb_d_reg  <= 1'b0;
      dclr_d_reg <= 1'b0;
    end else begin
      stb_d_reg  <= stb_s;
      dclr_d_reg <= dclr_s;
    end
  end

  // Byte assembly: high nibble first, low nibble completes the byte
  reg       hi_pend_reg;
  reg [3:0] hi_nib_reg;
  reg       byte_vld_reg;
  reg [7:0] byte_reg;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_pend_reg  <= 1'b0;
      hi_nib_reg   <= 4'h0;
      byte_vld_reg <= 1'b0;
      byte_reg     <= 8'h00;
    end else begin
      byte_vld_reg <= 1'b0;
      if (dclr_rise) begin
        // A clear drops a half-received byte so pairing restarts aligned
        hi_pend_reg <= 1'b0;
      end else if (stb_rise) begin
        if (!hi_pend_reg) begin
          hi_nib_reg  <= nib_s;
          hi_pend_reg <= 1'b1;
        end else begin
          byte_reg     <= {hi_nib_reg, nib_s};
          byte_vld_reg <= 1'b1;
          hi_pend_reg  <= 1'b0;
        end
      end
    end
  end

  // Digit test and value, used only by trigger-level mode
  function is_digit;
    input [7:0] c;
    begin
      is_digit = (c >= `ICC_CH_ZERO) && (c <= `ICC_CH_NINE);
    end
  endfunction

  function [3:0] digit_val;
    input [7:0] c;
    reg   [7:0] d;
    begin
      d = c - `ICC_CH_ZERO;
      digit_val = d[3:0];
    end
  endfunction

  // Command latches and mode state
  reg [`ICC_SET_W-1:0] set_a_reg;
  reg [`ICC_SET_W-1:0] set_b_reg;
  reg                  sep_reg;
  reg                  inv_reg;
  reg                  dac_mode_reg;
  reg                  sel_b_reg;

  wire       rx      = byte_vld_reg;
  wire       init_rx = rx & ~dac_mode_reg & (byte_reg == `ICC_CH_INIT);
  wire       clr_all = dclr_rise | init_rx;
  wire       sign_rx = rx & ~dac_mode_reg &
                       ((byte_reg == `ICC_CH_PLUS) | (byte_reg == `ICC_CH_MINUS));
  wire       dig_dac = rx & dac_mode_reg & is_digit(byte_reg);
  wire [3:0] dval    = digit_val(byte_reg);

  // Normal-mode decode; latches hold while in trigger-level mode, except that a device clear resets them
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      set_a_reg    <= SET_DEFAULT;
      set_b_reg    <= SET_DEFAULT;
      sep_reg      <= SEP_DEFAULT;
      inv_reg      <= INV_DEFAULT;
      dac_mode_reg <= 1'b0;
      sel_b_reg    <= 1'b0;
    end else if (clr_all) begin
      set_a_reg    <= SET_DEFAULT;
      set_b_reg    <= SET_DEFAULT;
      sep_reg      <= SEP_DEFAULT;
      inv_reg      <= INV_DEFAULT;
      dac_mode_reg <= 1'b0;
      sel_b_reg    <= 1'b0;
    end else if (rx && dac_mode_reg) begin
      if (byte_reg == `ICC_CH_STAR) begin
        dac_mode_reg <= 1'b0;
      end
    end else if (rx) begin
      case (byte_reg)
        `ICC_CH_A: begin
          sel_b_reg <= 1'b0;
        end
        `ICC_CH_B: begin
          sel_b_reg <= 1'b1;
        end
        `ICC_CH_PLUS, `ICC_CH_MINUS: begin
          dac_mode_reg <= 1'b1;
        end
        8'h31, 8'h36, 8'h37: begin
          if (sel_b_reg) begin
            set_b_reg[`ICC_SET_ATT_HI:`ICC_SET_ATT_LO] <= att_code(byte_reg);
          end else begin
            set_a_reg[`ICC_SET_ATT_HI:`ICC_SET_ATT_LO] <= att_code(byte_reg);
          end
        end
        8'h32, 8'h33: begin
          if (sel_b_reg) begin
            set_b_reg[`ICC_SET_AC] <= ~byte_reg[0];
          end else begin
            set_a_reg[`ICC_SET_AC] <= ~byte_reg[0];
          end
        end
        8'h34, 8'h35: begin
          if (sel_b_reg) begin
            set_b_reg[`ICC_SET_SLOPE] <= byte_reg[0];
          end else begin
            set_a_reg[`ICC_SET_SLOPE] <= byte_reg[0];
          end
        end
        8'h38, 8'h39: begin
          if (sel_b_reg) begin
            inv_reg <= byte_reg[0];
          end else begin
            sep_reg <= byte_reg[0];
          end
        end
        default: begin
          sel_b_reg <= sel_b_reg;
        end
      endcase
    end
  end

  // Attenuator code to field value: 1 is x100, 6 is x10, 7 is x1
  function [1:0] att_code;
    input [7:0] c;
    begin
      case (c[3:0])
        4'h1:    att_code = `ICC_ATT_X100;
        4'h6:    att_code = `ICC_ATT_X10;
        default: att_code = `ICC_ATT_X1;
      endcase
    end
  endfunction

  // Per-channel trigger-level registers
  wire [`ICC_LEVEL_W-1:0] lvl_a;
  wire [`ICC_LEVEL_W-1:0] lvl_b;
  wire [1:0]              cnt_a;
  wire [1:0]              cnt_b;

  icc_level_shift #(
    .LEVEL_DEFAULT (LEVEL_DEFAULT)
  ) u_level_a (
    .i_mclk       (i_mclk),
    .i_reset_n    (i_reset_n),
    .i_clear      (clr_all),
    .i_load_sign  (sign_rx & ~sel_b_reg),
    .i_negative   (byte_reg == `ICC_CH_MINUS),
    .i_load_digit (dig_dac & ~sel_b_reg),
    .i_digit      (dval),
    .o_level      (lvl_a),
    .o_count      (cnt_a)
  );

  icc_level_shift #(
    .LEVEL_DEFAULT (LEVEL_DEFAULT)
  ) u_level_b (
    .i_mclk       (i_mclk),
    .i_reset_n    (i_reset_n),
    .i_clear      (clr_all),
    .i_load_sign  (sign_rx & sel_b_reg),
    .i_negative   (byte_reg == `ICC_CH_MINUS),
    .i_load_digit (dig_dac & sel_b_reg),
    .i_digit      (dval),
    .o_level      (lvl_b),
    .o_count      (cnt_b)
  );

  // APB slave: one wait-free access phase, pready raised by the setup cycle
  reg [1:0] ctrl_reg;
  wire      setup   = i_psel & ~i_penable;
  wire      wr_acc  = i_psel & i_penable & o_pready & i_pwrite;
  wire      remote  = ctrl_reg[`ICC_CTRL_REMOTE];
  wire      check   = ctrl_reg[`ICC_CTRL_CHECK];

  function mapped;
    input [`ICC_ADDR_W-1:0] a;
    begin
      mapped = (a == `ICC_OFS_CTRL) || (a == `ICC_OFS_STATUS) ||
               (a == `ICC_OFS_SETTINGS) || (a == `ICC_OFS_LEVEL_A) ||
               (a == `ICC_OFS_LEVEL_B);
    end
  endfunction

  reg [31:0] rd_mux;

  // Read data selection
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `ICC_OFS_CTRL:     rd_mux = {30'h0, ctrl_reg};
      `ICC_OFS_STATUS:   rd_mux = {25'h0, hi_pend_reg, cnt_b, cnt_a, sel_b_reg, dac_mode_reg};
      `ICC_OFS_SETTINGS: rd_mux = {22'h0, inv_reg, sep_reg, set_b_reg, set_a_reg};
      `ICC_OFS_LEVEL_A:  rd_mux = {19'h0, lvl_a};
      `ICC_OFS_LEVEL_B:  rd_mux = {19'h0, lvl_b};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      ctrl_reg  <= `ICC_CTRL_RESET;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_pslverr <= ~mapped(i_paddr);
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h0000_0000;
      end
      // Only control is writable; writes elsewhere are dropped
      if (wr_acc && (i_paddr == `ICC_OFS_CTRL)) begin
        ctrl_reg <= i_pwdata[1:0];
      end
    end
  end

  // Relay source: latches in remote, panel in local, check forces its own word
  wire [`ICC_SET_W-1:0] eff_a = check ? SET_CHECK : (remote ? set_a_reg : fpa_s);
  wire [`ICC_SET_W-1:0] eff_b = check ? SET_CHECK : (remote ? set_b_reg : fpb_s);
  wire eff_sep = check ? 1'b0 : (remote ? sep_reg : fpsep_s);
  wire eff_inv = check ? 1'b0 : (remote ? inv_reg : fpinv_s);

  // Registered relay drivers, high energises; spare attenuator code 3 means unity
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_a_coupling_select      <= 1'b0;
      o_a_slope_neg            <= 1'b0;
      o_a_atten_x100           <= 1'b0;
      o_a_atten_x10            <= 1'b0;
      o_a_atten_x1             <= 1'b0;
      o_b_coupling_select      <= 1'b0;
      o_b_slope_neg            <= 1'b0;
      o_b_atten_x100           <= 1'b0;
      o_b_atten_x10            <= 1'b0;
      o_b_atten_x1             <= 1'b0;
      o_separate_common_select <= 1'b0;
      o_invert                 <= 1'b0;
      o_level_src_dac          <= 1'b0;
      o_a_level                <= LEVEL_DEFAULT;
      o_b_level                <= LEVEL_DEFAULT;
    end else begin
      o_a_coupling_select      <= eff_a[`ICC_SET_AC];
      o_a_slope_neg            <= eff_a[`ICC_SET_SLOPE];
      o_a_atten_x100           <= (eff_a[3:2] == `ICC_ATT_X100);
      o_a_atten_x10            <= (eff_a[3:2] == `ICC_ATT_X10);
      o_a_atten_x1             <= (eff_a[3:2] != `ICC_ATT_X100) && (eff_a[3:2] != `ICC_ATT_X10);
      o_b_coupling_select      <= eff_b[`ICC_SET_AC];
      o_b_slope_neg            <= eff_b[`ICC_SET_SLOPE];
      o_b_atten_x100           <= (eff_b[3:2] == `ICC_ATT_X100);
      o_b_atten_x10            <= (eff_b[3:2] == `ICC_ATT_X10);
      o_b_atten_x1             <= (eff_b[3:2] != `ICC_ATT_X100) && (eff_b[3:2] != `ICC_ATT_X10);
      o_separate_common_select <= eff_sep;
      o_invert                 <= eff_inv;
      o_level_src_dac          <= remote;
      o_a_level                <= lvl_a;
      o_b_level                <= lvl_b;
    end
  end

endmodule
`default_nettype wire

// >>> logic/placeholder_none.v
// Intentionally empty design unit kept out of build
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verif/icc_checker.sv
// Port assertions for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module icc_checker (
  // Clock, reset and APB
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Panel levels and relay controls
  input wire logic [3:0]  i_fp_a_sw,
  input wire logic        i_fp_separate_common,
  input wire logic        i_fp_invert,
  input wire logic        o_a_coupling_select,
  input wire logic        o_a_slope_neg,
  input wire logic        o_a_atten_x100,
  input wire logic        o_a_atten_x10,
  input wire logic        o_a_atten_x1,
  input wire logic        o_b_atten_x100,
  input wire logic        o_b_atten_x10,
  input wire logic        o_b_atten_x1,
  input wire logic        o_separate_common_select,
  input wire logic        o_invert,
  input wire logic        o_level_src_dac
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  logic [1:0] ctrl_reg;
  logic [5:0] pan_reg;
  logic [2:0] calm_reg;
  wire        ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h00;
  wire [5:0]  pan_now = {i_fp_a_sw, i_fp_separate_common, i_fp_invert};
  // Control shadow and settle count; panel pins pass a synchroniser first
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_reg <= 2'h0;
      pan_reg  <= 6'h0;
      calm_reg <= 3'h0;
    end else begin
      pan_reg <= pan_now;
      if (ctrl_wr)
        ctrl_reg <= i_pwdata[1:0];
      if (ctrl_wr || pan_reg != pan_now)
        calm_reg <= 3'h0;
      else if (calm_reg != 3'h7)
        calm_reg <= calm_reg + 3'h1;
    end
  end
  // Relay and bus relations
  a_atten_a_onehot: assert property ($past(i_reset_n, 6) |-> $onehot({o_a_atten_x100, o_a_atten_x10, o_a_atten_x1}))
    else $error("channel A attenuator relays not one-hot");
  a_atten_b_onehot: assert property ($past(i_reset_n, 6) |-> $onehot({o_b_atten_x100, o_b_atten_x10, o_b_atten_x1}))
    else $error("channel B attenuator relays not one-hot");
  a_setup_ready: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in first access cycle");
  a_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("ready without a setup cycle");
  a_err_map: assert property (o_pready |-> o_pslverr == !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
    else $error("error flag does not match address map");
  a_rdata_idle: assert property (!o_pready || i_pwrite |-> o_prdata == 32'h0)
    else $error("read data outside a read access");
  a_src_follow: assert property (ctrl_wr |-> ##2 o_level_src_dac == $past(i_pwdata[0], 2))
    else $error("level source does not follow remote bit");
  a_local_pass: assert property (calm_reg == 3'h7 && pan_reg == pan_now && ctrl_reg == 2'h0 |->
    o_a_coupling_select == i_fp_a_sw[0] && o_a_slope_neg == i_fp_a_sw[1]
    && o_separate_common_select == i_fp_separate_common && o_invert == i_fp_invert)
    else $error("panel levels not passed through in local");
  a_check_force: assert property (calm_reg == 3'h7 && ctrl_reg[1] |-> !o_a_coupling_select
    && !o_a_slope_neg && o_a_atten_x1 && !o_separate_common_select && !o_invert)
    else $error("check mode does not force relay settings");
  // Main scenarios
  c_check: cover property (ctrl_wr && i_pwdata[1]);
  c_unmapped: cover property (o_pready && o_pslverr);
  c_remote: cover property ($rose(o_level_src_dac));
endmodule
bind icc_interpreter icc_checker i_icc_checker (.*);
`default_nettype wire

// >>> verif/icc_cmd_sender.sv
// Remote command path model: sends each character as two nibbles
`timescale 1ns/1ps
`default_nettype none
module icc_cmd_sender (
  // Clock
  input  wire logic       i_mclk,
  // Command path pins
  output var  logic [3:0] o_command_data_lines,
  output var  logic       o_cmd_strobe
);
  // Idle lines at time zero
  initial begin
    o_command_data_lines = 4'h0;
    o_cmd_strobe = 1'h0;
  end
  // Data settles, strobe rises, then data goes stale so no old value lingers
  task automatic send_nibble(input logic [3:0] n);
    @(posedge i_mclk);
    o_command_data_lines <= n;
    repeat (3) @(posedge i_mclk);
    o_cmd_strobe <= 1'h1;
    repeat (4) @(posedge i_mclk);
    o_command_data_lines <= ~n;
    o_cmd_strobe <= 1'h0;
    repeat (4) @(posedge i_mclk);
  endtask
  // High nibble first; channel prefix and terminator come from the caller's text
  task automatic send_char(input logic [7:0] c);
    send_nibble(c[7:4]);
    send_nibble(c[3:0]);
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "icc_defs.vh"
module testbench;
  logic        i_mclk = 1'h0, i_reset_n = 1'h0;
  logic        i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, i_dev_clear = 1'h0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic        o_pready, o_pslverr, err, i_cmd_strobe, i_fp_separate_common = 1'h0, i_fp_invert = 1'h0;
  logic [3:0]  i_command_data_lines, i_fp_a_sw = 4'h0, i_fp_b_sw = 4'h0;
  logic        o_a_coupling_select, o_a_slope_neg, o_a_atten_x100, o_a_atten_x10, o_a_atten_x1;
  logic        o_b_coupling_select, o_b_slope_neg, o_b_atten_x100, o_b_atten_x10, o_b_atten_x1;
  logic        o_separate_common_select, o_invert, o_level_src_dac;
  logic [12:0] o_a_level, o_b_level;
  int          mismatches = 0, total_checks = 0;
  // Model: per-channel settings, levels, digit counts; shared flags
  int          mset[2], mlev[2], mcnt[2], msep, minv, mmode, msel, remote = 0, chk = 0;
  string       alpha = "AB0123456789P+-*Z.";
  wire [11:0]  relays = {o_a_coupling_select, o_a_slope_neg, o_a_atten_x100, o_a_atten_x10, o_a_atten_x1,
                         o_b_coupling_select, o_b_slope_neg, o_b_atten_x100, o_b_atten_x10, o_b_atten_x1,
                         o_separate_common_select, o_invert};
  always #2 i_mclk = ~i_mclk;
  icc_interpreter i_icc_interpreter (.*);
  icc_cmd_sender i_icc_cmd_sender (.i_mclk(i_mclk), .o_command_data_lines(i_command_data_lines),
                                   .o_cmd_strobe(i_cmd_strobe));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Setting word to relay lines; attenuator code 3 falls back to unity
  function automatic logic [4:0] deco(input int s);
    return {s[0], s[1], s[3:2] == 2, s[3:2] == 1, s[3:2] != 1 && s[3:2] != 2};
  endfunction
  function automatic logic [11:0] exp_relays();
    if (chk)
      return {deco(`ICC_SET_CHECK), deco(`ICC_SET_CHECK), 2'h0};
    if (!remote)
      return {deco(i_fp_a_sw), deco(i_fp_b_sw), i_fp_separate_common, i_fp_invert};
    return {deco(mset[0]), deco(mset[1]), msep[0], minv[0]};
  endfunction
  task automatic mreset();
    mset = '{`ICC_SET_DEFAULT, `ICC_SET_DEFAULT};
    mlev = '{`ICC_LEVEL_DEFAULT, `ICC_LEVEL_DEFAULT};
    mcnt = '{0, 0};
    msep = `ICC_SEP_DEFAULT;
    minv = `ICC_INV_DEFAULT;
    mmode = 0;
    msel = 0;
  endtask
  // One character through the model; unknown characters fall out untouched
  task automatic model(input logic [7:0] c);
    int d;
    d = c - 8'h30;
    if (mmode) begin
      if (c == `ICC_CH_STAR)
        mmode = 0;
      else if (d >= 0 && d <= 9 && mcnt[msel] < 3) begin
        mlev[msel] = (mlev[msel] & 32'h1000) | ((mlev[msel] << 4) & 32'hff0) | d;
        mcnt[msel]++;
      end
    end else if (c == `ICC_CH_A || c == `ICC_CH_B)
      msel = c[1];
    else if (c == `ICC_CH_PLUS || c == `ICC_CH_MINUS) begin
      mmode = 1;
      mlev[msel] = (c == `ICC_CH_MINUS) ? 32'h1000 : 32'h0;
      mcnt[msel] = 0;
    end else if (c == `ICC_CH_INIT)
      mreset();
    else if (d == 8 || d == 9) begin
      if (msel)
        minv = d - 8;
      else
        msep = d - 8;
    end else
      case (d)
        1: mset[msel][3:2] = 2'h2;
        2: mset[msel][0] = 1'h1;
        3: mset[msel][0] = 1'h0;
        4: mset[msel][1] = 1'h0;
        5: mset[msel][1] = 1'h1;
        6: mset[msel][3:2] = 2'h1;
        7: mset[msel][3:2] = 2'h0;
        default: ;
      endcase
  endtask
  task automatic compare();
    check("relays", relays, exp_relays());
    check("level_a", o_a_level, mlev[0]);
    check("level_b", o_b_level, mlev[1]);
    check("level_src", o_level_src_dac, remote);
  endtask
  // APB master: hold the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'h1;
    @(posedge i_mclk);
    while (o_pready !== 1'h1)
      @(posedge i_mclk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  // Panel moves at random under every character; remote must not follow it
  task automatic send_one(input logic [7:0] c);
    {i_fp_a_sw, i_fp_b_sw, i_fp_separate_common, i_fp_invert} <= 10'($urandom);
    i_icc_cmd_sender.send_char(c);
    model(c);
    repeat (4) @(posedge i_mclk);
    compare();
  endtask
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
      send_one(s[i]);
  endtask
  initial begin
    void'($urandom(32'h490a));
    mreset();
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'h1;
    repeat (8) @(posedge i_mclk);
    compare();
    apb(1'h0, `ICC_OFS_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    check("unmapped_err", err, 32'h1);
    apb(1'h1, `ICC_OFS_STATUS, 32'hff);
    check("ro_err", err, 32'h0);
    send("A2A4A1A9B3B5B6B8");
    apb(1'h1, `ICC_OFS_CTRL, 32'h1);
    remote = 1;
    repeat (6) @(posedge i_mclk);
    compare();
    send("A3A8B9A7B2B1A6A5Z");
    send("A-1.25*B+26P54*A5");
    repeat (40) send_one(alpha[$urandom_range(17, 0)]);
    send("*");
    apb(1'h0, `ICC_OFS_SETTINGS, 32'h0);
    check("settings", rd, {minv[0], msep[0], mset[1][3:0], mset[0][3:0]});
    apb(1'h0, `ICC_OFS_STATUS, 32'h0);
    check("status", rd, {mcnt[1][1:0], mcnt[0][1:0], msel[0], mmode[0]});
    apb(1'h0, `ICC_OFS_LEVEL_A, 32'h0);
    check("level_a_reg", rd, mlev[0]);
    apb(1'h1, `ICC_OFS_CTRL, 32'h3);
    chk = 1;
    repeat (6) @(posedge i_mclk);
    send("B2");
    apb(1'h1, `ICC_OFS_CTRL, 32'h1);
    chk = 0;
    send("A2B5");
    i_dev_clear <= 1'h1;
    repeat (4) @(posedge i_mclk);
    i_dev_clear <= 1'h0;
    repeat (8) @(posedge i_mclk);
    mreset();
    compare();
    send("A5B-3*P");
    apb(1'h1, `ICC_OFS_CTRL, 32'h0);
    remote = 0;
    repeat (8) @(posedge i_mclk);
    compare();
    wrap_up();
  end
  // Cut a hang short; the whole sequence needs well under 5000 cycles
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
